// ---- mgmt_regs_defs.svh ----
// Offsets, field positions, reset values and timing counts for the management register bank
`ifndef MGMT_REGS_DEFS_SVH
`define MGMT_REGS_DEFS_SVH

// Register byte offsets
`define OFS_PORT_SELECT      12'h064
`define OFS_INTEG_CTRL       12'hf00
`define OFS_UNLOCK_WORD      12'hfb0
`define OFS_LOCK_STATE       12'hfb4
`define OFS_CAP_ONE          12'hfc4
`define OFS_CAP_TWO          12'hfc8
`define OFS_TYPE_CLASS       12'hfcc
`define OFS_IDENT_FOUR       12'hfd0
`define OFS_IDENT_FIVE       12'hfd4
`define OFS_IDENT_SIX        12'hfd8
`define OFS_IDENT_SEVEN      12'hfdc
`define OFS_IDENT_ZERO       12'hfe0
`define OFS_IDENT_ONE        12'hfe4
`define OFS_IDENT_TWO        12'hfe8
`define OFS_IDENT_THREE      12'hfec
`define OFS_ENGINE_STATUS    12'hf10

// Field positions
`define FLD_INTEG_ENABLE     0
`define FLD_REGISTERED_CODE  3
`define FLD_IDLE             0
`define FLD_ENGINE_ACTIVE    1
`define FLD_CMD_COUNT_LO     4

// Reset values
`define RST_INTEG_CTRL       1'b0
`define RST_RDATA            32'h0000_0000
`define TYPE_CLASS_VALUE     8'h00

// Timing: read data latency of one cycle after the request is seen
`define READ_WAIT_CYCLES     1

`endif

// ---- mgmt_regs_pkg.sv ----
// Types shared by the management register bank modules
package mgmt_regs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ANSWER = 2'b01
  } bus_state_e;

  typedef logic [31:0] word_t;
endpackage

// ---- ident_if.sv ----
// Interface carrying the identification words between the bank and its ROM
`timescale 1ns/10ps
interface ident_if;
  logic [2:0]  index;    // Identification word number
  logic [31:0] word;     // Identification word value

  modport bank (output index, input word);
  modport rom  (input index, output word);
endinterface

// ---- ident_rom.sv ----
// Constant identification word lookup
`timescale 1ns/10ps
module ident_rom #(
  parameter logic [7:0] PART_LOW   = 8'h00, // Arbitrary part number low byte
  parameter logic [3:0] PART_HIGH  = 4'h0,  // Arbitrary part number high nibble
  parameter logic [6:0] MAKER_CODE = 7'h00, // Arbitrary maker code
  parameter logic [3:0] MAKER_CONT = 4'h0,  // Arbitrary continuation count
  parameter logic [3:0] REVISION   = 4'h0,  // Arbitrary revision
  parameter logic [3:0] SIZE_CODE  = 4'h0   // Block count code
) (
  ident_if.rom ids                         // Word index in, word out
);
  // Words zero to four carry only eight low bits, five to seven are zero
  always_comb begin
    ids.word = 32'h0000_0000;
    case (ids.index)
      3'h0: ids.word[7:0] = PART_LOW;
      3'h1: ids.word[7:0] = {MAKER_CODE[3:0], PART_HIGH};
      3'h2: ids.word[7:0] = {REVISION, 1'b1, MAKER_CODE[6:4]};
      3'h3: ids.word[7:0] = 8'h00;
      3'h4: ids.word[7:0] = {SIZE_CODE, MAKER_CONT};
      default: ids.word = 32'h0000_0000;
    endcase
  end
endmodule

// ---- mgmt_regs.sv ----
// Management and identification register bank with port selection
`timescale 1ns/10ps
`include "mgmt_regs_defs.svh"
module mgmt_regs #(
  parameter int         NUM_PORTS       = 8,       // Number of port select bits
  parameter logic [7:0] PORT_CONNECTED  = 8'hff,   // Ports wired to this block
  parameter logic [7:0] KEEP_UNCONNECTED = 8'h00,  // Unconnected bits kept as storage
  parameter bit         HAS_INTEGRATION = 1'b1,    // Integration support present
  parameter int         CMD_COUNT_W     = 3        // Width of command count field
) (
  input  wire logic                   clk_in,               // 100 MHz clock
  input  wire logic                   rst_b_in,             // Async reset, active low
  input  wire logic [11:0]            avs_address_in,       // Byte address
  input  wire logic                   avs_read_in,          // Read request
  input  wire logic                   avs_write_in,         // Write request
  input  wire logic [3:0]             avs_byteenable_in,    // Byte lanes
  input  wire logic [31:0]            avs_writedata_in,     // Write data
  output logic [31:0]                 avs_readdata_out,     // Read data
  output logic                        avs_waitrequest_out,  // Stall
  output logic [1:0]                  avs_response_out,     // Always okay
  input  wire logic                   engine_active_in,     // Engine busy flag
  input  wire logic [CMD_COUNT_W-1:0] command_fifo_count_in,// Pending command bytes
  output logic [NUM_PORTS-1:0]        port_select_bit_out,  // Selected ports
  output logic                        integration_mode_enable_out, // Integration mode
  output logic                        engine_idle_out       // Engine definitely idle
);

  // Bank state held as a single record
  typedef struct packed {
    mgmt_regs_pkg::bus_state_e bus_state;
    logic [31:0]               rdata;
    logic                      integ;
    logic [NUM_PORTS-1:0]      psel;
  } bank_s;

  bank_s state_q;
  bank_s state_d;

  ident_if ids ();

  // Identification words come from a constant table
  ident_rom u_ident_rom (
    .ids (ids.rom)
  );

  logic                   access;
  logic [NUM_PORTS-1:0]   psel_impl;
  logic [31:0]            read_word;
  logic [7:0]             psel_bytes;
  logic                   idle_now;

  // Bits that exist as storage: connected ports, or unconnected ones kept by choice
  assign psel_impl = PORT_CONNECTED[NUM_PORTS-1:0] | KEEP_UNCONNECTED[NUM_PORTS-1:0];
  assign access    = avs_read_in | avs_write_in;

  // Idle only when both status fields are zero
  assign idle_now = ~engine_active_in & (command_fifo_count_in == '0);

  // Identification index from low address bits; words four to seven sit below zero,
  // so address bit 4 set means the upper half of the table
  assign ids.index = {avs_address_in[4], avs_address_in[3:2]};

  // Port select widened to a byte for the read mux
  always_comb begin
    psel_bytes = 8'h00;
    psel_bytes[NUM_PORTS-1:0] = state_q.psel & psel_impl;
  end

  // Read mux; unmapped words and write-only words read zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (avs_address_in)
      `OFS_PORT_SELECT:   read_word[7:0] = psel_bytes;
      `OFS_INTEG_CTRL:    read_word[`FLD_INTEG_ENABLE] = state_q.integ;
      `OFS_LOCK_STATE:    read_word = 32'h0000_0000;
      `OFS_CAP_ONE:       read_word = 32'h0000_0000;
      `OFS_CAP_TWO:       read_word = 32'h0000_0000;
      `OFS_TYPE_CLASS:    read_word[7:0] = `TYPE_CLASS_VALUE;
      `OFS_IDENT_FOUR,
      `OFS_IDENT_FIVE,
      `OFS_IDENT_SIX,
      `OFS_IDENT_SEVEN,
      `OFS_IDENT_ZERO,
      `OFS_IDENT_ONE,
      `OFS_IDENT_TWO,
      `OFS_IDENT_THREE:   read_word = ids.word;
      `OFS_ENGINE_STATUS: begin
        read_word[`FLD_IDLE]          = idle_now;
        read_word[`FLD_ENGINE_ACTIVE] = engine_active_in;
        read_word[`FLD_CMD_COUNT_LO +: CMD_COUNT_W] = command_fifo_count_in;
      end
      default:            read_word = 32'h0000_0000;
    endcase
  end

  // Next state: one wait cycle, then answer with waitrequest low
  always_comb begin
    state_d = state_q;
    case (state_q.bus_state)
      mgmt_regs_pkg::ST_IDLE: begin
        if (access) begin
          state_d.bus_state = mgmt_regs_pkg::ST_ANSWER;
          state_d.rdata     = avs_read_in ? read_word : `RST_RDATA;
        end
      end
      mgmt_regs_pkg::ST_ANSWER: begin
        state_d.bus_state = mgmt_regs_pkg::ST_IDLE;
        // Writes land at the answering edge only
        if (avs_write_in) begin
          case (avs_address_in)
            `OFS_INTEG_CTRL: begin
              // Only lane 0 holds the one live bit; upper bits are dropped
              if (HAS_INTEGRATION && avs_byteenable_in[0]) begin
                state_d.integ = avs_writedata_in[`FLD_INTEG_ENABLE];
              end
            end
            `OFS_PORT_SELECT: begin
              // Caller guarantees engine idle; no guard, matching the unpredictable case
              if (avs_byteenable_in[0]) begin
                state_d.psel = (avs_writedata_in[NUM_PORTS-1:0] & psel_impl)
                             | (state_q.psel & ~psel_impl);
              end
            end
            `OFS_UNLOCK_WORD: state_d = state_q;
            default:          state_d = state_q;
          endcase
          state_d.bus_state = mgmt_regs_pkg::ST_IDLE;
        end
      end
      default: state_d.bus_state = mgmt_regs_pkg::ST_IDLE;
    endcase
  end

  // Port select is left out of the reset and holds through it; software writes it before use
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q.bus_state <= mgmt_regs_pkg::ST_IDLE;
      state_q.rdata     <= `RST_RDATA;
      state_q.integ     <= `RST_INTEG_CTRL;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus outputs
  assign avs_waitrequest_out = ~(state_q.bus_state == mgmt_regs_pkg::ST_ANSWER);
  assign avs_readdata_out    = state_q.rdata;
  assign avs_response_out    = 2'b00;

  // Block outputs
  assign port_select_bit_out         = state_q.psel & psel_impl;
  assign integration_mode_enable_out = HAS_INTEGRATION ? state_q.integ : 1'b0;
  assign engine_idle_out             = idle_now;

endmodule

// ---- mgmt_regs_sva.sv ----
// Assertions on the register bank ports
`timescale 1ns/10ps
module mgmt_regs_sva #(
  parameter int NUM_PORTS   = 8, // Select bits
  parameter int CMD_COUNT_W = 3  // Count width
) (
  input wire logic                   clk_in,                      // Clock
  input wire logic                   rst_b_in,                    // Reset
  input wire logic [11:0]            avs_address_in,              // Address
  input wire logic                   avs_read_in,                 // Read
  input wire logic                   avs_write_in,                // Write
  input wire logic [3:0]             avs_byteenable_in,           // Lanes
  input wire logic [31:0]            avs_writedata_in,            // Wdata
  input wire logic [31:0]            avs_readdata_out,            // Rdata
  input wire logic                   avs_waitrequest_out,         // Stall
  input wire logic [1:0]             avs_response_out,            // Resp
  input wire logic                   engine_active_in,            // Busy
  input wire logic [CMD_COUNT_W-1:0] command_fifo_count_in,       // Count
  input wire logic [NUM_PORTS-1:0]   port_select_bit_out,         // Select
  input wire logic                   integration_mode_enable_out, // Mode
  input wire logic                   engine_idle_out              // Idle
);
  // Accepted transfers; lane 0 gates writes
  wire wa = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire ra = avs_read_in && !avs_waitrequest_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("answer late");
  AST_SHORT_ANSWER: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer too long");
  AST_RESP_OKAY: assert property (avs_response_out == 2'h0) else $error("bad response");
  AST_IDLE_FLAG: assert property (engine_idle_out ==
    (!engine_active_in && command_fifo_count_in == '0)) else $error("idle flag wrong");
  AST_MODE_WRITE: assert property (wa && avs_address_in == 12'hf00
    |=> integration_mode_enable_out == $past(avs_writedata_in[0])) else $error("mode lost");
  AST_MODE_HOLD: assert property (!(wa && avs_address_in == 12'hf00)
    |=> $stable(integration_mode_enable_out)) else $error("mode moved");
  AST_SELECT_WRITE: assert property (wa && avs_address_in == 12'h064
    |=> port_select_bit_out == $past(avs_writedata_in[7:0])) else $error("select lost");
  AST_ZERO_WORDS: assert property (ra && avs_address_in inside {12'hfb4, 12'hfc4,
    12'hfc8, 12'hfcc, 12'hfd4, 12'hfd8, 12'hfdc} |-> avs_readdata_out == 32'h0)
    else $error("word not zero");
  AST_CODE_BIT: assert property (ra && avs_address_in == 12'hfe8 |-> avs_readdata_out[3])
    else $error("code bit low");
  // Main scenarios reached
  COV_SELECT: cover property (wa && avs_address_in == 12'h064);
  COV_MODE_ON: cover property (wa && avs_address_in == 12'hf00 && avs_writedata_in[0]);
  COV_IDENT: cover property (ra && avs_address_in == 12'hfe8);
endmodule

// ---- engine_model.sv ----
// Serial engine status source feeding the bank's idle inputs
`timescale 1ns/10ps
module engine_model (
  input  wire logic       clk_in,      // Clock
  input  wire logic       busy_req_in, // Wanted busy state
  input  wire logic [2:0] cnt_req_in,  // Wanted queue depth
  output logic            active_out,  // Engine busy
  output logic [2:0]      count_out    // Pending bytes
);
  // Registered like a real engine, so status lags the request one edge
  always_ff @(posedge clk_in) begin
    active_out <= busy_req_in;
    count_out  <= cnt_req_in;
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the management register bank
`timescale 1ns/10ps
module tb;
  logic        clk_in, rst_b_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [11:0] avs_address_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [1:0]  avs_response_out;
  logic [2:0]  command_fifo_count_in, cnt_req;
  logic [7:0]  port_select_bit_out;
  logic        integration_mode_enable_out, engine_active_in, engine_idle_out, busy_req;
  int          n_fail, total_checks, cyc;
  mgmt_regs u_mgmt_regs (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .avs_response_out, .engine_active_in, .command_fifo_count_in, .port_select_bit_out,
    .integration_mode_enable_out, .engine_idle_out);
  engine_model u_engine_model (.clk_in, .busy_req_in(busy_req), .cnt_req_in(cnt_req),
    .active_out(engine_active_in), .count_out(command_fifo_count_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until the rising edge that sees waitrequest low, then releases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    // No local limit: only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask
  // Read-only words: written with ones first, must still read as fixed
  task automatic t_const();
    logic [11:0] a [13] = '{12'hfb4, 12'hfc4, 12'hfc8, 12'hfcc, 12'hfd4, 12'hfd8, 12'hfdc,
                            12'hfd0, 12'hfe0, 12'hfe4, 12'hfec, 12'hfe8, 12'h200};
    logic [31:0] m;
    bus(1'b1, 12'hfb0, 32'hffff_ffff, 4'hf);
    for (int i = 0; i < 13; i++) begin
      m = (i > 6 && i < 11) ? 32'hffff_ff00 : (i == 11) ? 32'hffff_ff08 : 32'hffff_ffff;
      bus(1'b1, a[i], 32'hffff_ffff, 4'hf);
      bus(1'b0, a[i], 32'h0, 4'hf);
      chk(q & m, (i == 11) ? 32'h8 : 32'h0);
    end
  endtask
  task automatic t_integ();
    rd(12'hf00, 32'h0);
    bus(1'b1, 12'hf00, 32'hffff_ffff, 4'hf);
    rd(12'hf00, 32'h1);
    chk({31'h0, integration_mode_enable_out}, 32'h1);
    bus(1'b1, 12'hf00, 32'h0, 4'he);
    rd(12'hf00, 32'h1);
    bus(1'b1, 12'hf00, 32'h0, 4'hf);
    rd(12'hf00, 32'h0);
    chk({31'h0, integration_mode_enable_out}, 32'h0);
    bus(1'b1, 12'hf00, 32'h1, 4'hf);
    rst_b_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(12'hf00, 32'h0);
  endtask
  task automatic eng(input logic b, input logic [2:0] c, input logic e);
    @(posedge clk_in);
    busy_req <= b;
    cnt_req <= c;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk({31'h0, engine_idle_out}, {31'h0, e});
    // Status word: count in bits 6:4, active in bit 1, idle in bit 0
    rd(12'hf10, {25'h0, c, 2'b00, b, e});
  endtask
  // Selection only after the engine reads idle
  task automatic t_psel();
    logic [7:0] p [5] = '{8'ha5, 8'h5a, 8'hff, 8'h01, 8'h00};
    eng(1'b1, 3'h0, 1'b0);
    eng(1'b0, 3'h7, 1'b0);
    eng(1'b0, 3'h0, 1'b1);
    rd(12'hf10, 32'h1);
    foreach (p[i]) begin
      bus(1'b1, 12'h064, {24'hff_ffff, p[i]}, 4'hf);
      rd(12'h064, {24'h0, p[i]});
      chk({24'h0, port_select_bit_out}, {24'h0, p[i]});
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cycle ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {n_fail, total_checks, cyc} = '0;
    {rst_b_in, avs_read_in, avs_write_in, busy_req, cnt_req} = '0;
    {avs_address_in, avs_byteenable_in, avs_writedata_in} = '0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_const();
    t_integ();
    t_psel();
    final_report();
  end
endmodule
bind mgmt_regs mgmt_regs_sva #(.NUM_PORTS(NUM_PORTS), .CMD_COUNT_W(CMD_COUNT_W)) u_sva (
  .clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_byteenable_in,
  .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out,
  .engine_active_in, .command_fifo_count_in, .port_select_bit_out,
  .integration_mode_enable_out, .engine_idle_out);
